// ---- rtl/i2css_top.sv ----
// Contract
// - byte done without error sets data flag
// - write one clears data flag
// - data access or command clears data flag
// - address match or stop sets address flag
// - address flag cleared like data flag
// - flags hold scl low outside idle, status bit five
// - bit four holds last master ack
// - collision sets flag, stops driving low
// - collision still ends with flag set
// - collision flag cleared by start or write
// - illegal start or stop sets bus error, only while master_enable_i is high
// - bit one holds last direction bit
// - bit zero tells address or stop cause
// - match uses own address and mask
// - own bits seven-one address, bit zero general
// - ten-bit first byte only, software second
// - ack choice and command in one write
// - stop sets flag only when enabled
// - match-any bit accepts every address
// - mask ignores bits or holds second address
//
// Chosen here: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "i2css_defines.svh"
module i2css_top (
  // clock, enable, reset
  input  wire logic        core_clk_i,
  input  wire logic        clk_en_i,
  input  wire logic        rst_b_i,
  // ahb-lite slave
  input  wire logic        hsel_i,
  input  wire logic [31:0] haddr_i,
  input  wire logic [1:0]  htrans_i,
  input  wire logic        hwrite_i,
  input  wire logic [2:0]  hsize_i,
  input  wire logic [31:0] hwdata_i,
  input  wire logic        hready_i,
  output logic             hreadyout_o,
  output logic             hresp_o,
  output logic [31:0]      hrdata_o,
  // two-wire pins
  input  wire logic        scl_i,
  output logic             scl_o,
  output logic             scl_oe_o,
  input  wire logic        sda_i,
  output logic             sda_o,
  output logic             sda_oe_o,
  // neighbouring master logic
  input  wire logic        master_enable_i
);
  // ----------------------------------------
  // declarations
  // ----------------------------------------
  i2css_pkg::i2css_line_t  s1_ff;     // first sync stage
  i2css_pkg::i2css_line_t  s2_ff;     // second sync stage
  i2css_pkg::i2css_line_t  d_ff;      // previous sample
  i2css_pkg::i2css_state_t state_ff;  // byte engine state
  i2css_pkg::i2css_status_t st_rd;    // status view
  logic [3:0]  bit_ff;                // bit counter
  logic [7:0]  shift_ff;              // shift register
  logic [7:0]  ctrla_ff;              // control a
  logic        ack_ff;                // ack choice
  logic [7:0]  own_ff;                // own address
  logic [7:0]  mask_ff;               // mask / second address
  logic        dif_ff;
  logic        address_or_stop_flag_ff;
  logic        stretch_ff;
  logic        master_ack_seen_ff;
  logic        transmit_clash_flag_ff;
  logic        berr_ff;
  logic        dir_ff;
  logic        ap_ff;
  logic        sda_drv_ff;            // engine wants sda low
  logic        comp_ff;               // complete waits for ack bit
  logic        wr_pend_ff;            // write data phase due
  logic [7:0]  widx_ff;               // write index
  logic [31:0] hrdata_ff;
  // ----------------------------------------
  // line events
  // ----------------------------------------
  wire scl_rise = s2_ff.scl & ~d_ff.scl;
  wire scl_fall = ~s2_ff.scl & d_ff.scl;
  wire start_det = s2_ff.scl & d_ff.scl & d_ff.sda & ~s2_ff.sda;
  wire stop_det = s2_ff.scl & d_ff.scl & ~d_ff.sda & s2_ff.sda;
  wire st_idle = (state_ff == i2css_pkg::ST_IDLE);
  wire st_addr = (state_ff == i2css_pkg::ST_ADDR);
  wire st_sack = (state_ff == i2css_pkg::ST_SACK);
  wire st_rx = (state_ff == i2css_pkg::ST_RX);
  wire st_tx = (state_ff == i2css_pkg::ST_TX);
  wire st_mack = (state_ff == i2css_pkg::ST_MACK);
  wire byte_end = (bit_ff == `I2CSS_BITS);
  wire en = ctrla_ff[`I2CSS_CA_EN];
  // ----------------------------------------
  // bus decode
  // ----------------------------------------
  wire [7:0] a_idx = haddr_i[9:2];
  wire acc_a = hsel_i & hready_i & htrans_i[`I2CSS_HT_ACT];
  wire rd_a = acc_a & ~hwrite_i;
  wire wr_a = acc_a & hwrite_i;
  wire [7:0] wdat = hwdata_i[7:0];
  wire wr_ctrla = wr_pend_ff & (widx_ff == `I2CSS_IDX_CTRLA);
  wire wr_ctrlb = wr_pend_ff & (widx_ff == `I2CSS_IDX_CTRLB);
  wire wr_stat = wr_pend_ff & (widx_ff == `I2CSS_IDX_STATUS);
  wire wr_own = wr_pend_ff & (widx_ff == `I2CSS_IDX_OWN);
  wire wr_data = wr_pend_ff & (widx_ff == `I2CSS_IDX_DATA);
  wire wr_mask = wr_pend_ff & (widx_ff == `I2CSS_IDX_MASK);
  wire rd_data = rd_a & (a_idx == `I2CSS_IDX_DATA);
  // valid commands are the two with the high code bit
  wire cmd_ok = wr_ctrlb & wdat[1];
  wire cmd_comp = wr_ctrlb & (wdat[1:0] == `I2CSS_CMD_COMP);
  wire ack_now = wr_ctrlb ? wdat[`I2CSS_CB_ACK] : ack_ff;
  wire comp_ack = cmd_comp & st_sack & ~dir_ff; // ack bit first, then idle
  wire sw_clr = cmd_ok | wr_data | rd_data;
  // ----------------------------------------
  // read selection
  // ----------------------------------------
  assign st_rd = '{dif_ff, address_or_stop_flag_ff, stretch_ff, master_ack_seen_ff,
                   transmit_clash_flag_ff, berr_ff, dir_ff, ap_ff};
  wire [7:0] rd_val =
    (a_idx == `I2CSS_IDX_CTRLA)  ? (ctrla_ff & `I2CSS_CA_RMASK) :
    (a_idx == `I2CSS_IDX_CTRLB)  ? {5'h00, ack_ff, 2'h0} :
    (a_idx == `I2CSS_IDX_STATUS) ? st_rd :
    (a_idx == `I2CSS_IDX_OWN)    ? own_ff :
    (a_idx == `I2CSS_IDX_DATA)   ? shift_ff :
    (a_idx == `I2CSS_IDX_MASK)   ? mask_ff : `I2CSS_REG_RST;
  // ----------------------------------------
  // address match
  // ----------------------------------------
  wire [6:0] rx_a = shift_ff[7:1];
  wire sel2 = mask_ff[0];
  // mask bits force match unless second address
  wire [6:0] ign = sel2 ? 7'h00 : mask_ff[7:1];
  // compare against own address with mask
  wire m_own = (((rx_a ^ own_ff[7:1]) & ~ign) == 7'h00);
  wire m_two = sel2 & (rx_a == mask_ff[7:1]);
  wire m_gc = own_ff[0] & (rx_a == `I2CSS_GC_ADDR);
  wire m_any = ctrla_ff[`I2CSS_CA_ANY];
  // ten-bit first byte is plain 11110aa pattern
  wire match = m_any | m_gc | m_own | m_two;
  // ----------------------------------------
  // engine events
  // ----------------------------------------
  wire a_done = st_addr & scl_fall & byte_end;
  wire r_done = st_rx & scl_fall & byte_end;
  wire k_done = st_sack & scl_fall;
  wire m_done = st_mack & scl_fall;
  // bus errors need master circuitry enabled
  wire berr_set = master_enable_i & (start_det | stop_det)
                  & (((st_rx | st_tx | st_addr) & (bit_ff != 4'h0))
                  | (stop_det & st_addr));
  // data flag after rx byte, tx load point, tx ack
  // set even when the byte collided
  wire dif_set = (r_done & ~berr_set)
               | (k_done & ~ack_ff & dir_ff)
               | m_done;
  // match or enabled stop sets address flag
  // stop only while stop flag enabled
  wire ap_match = a_done & match;
  wire address_or_stop_flag_set = ap_match | (stop_det & ctrla_ff[`I2CSS_CA_STOPEN]);
  // collision when high bit or nack meets low sda
  wire transmit_clash_flag_set = scl_rise & ~s2_ff.sda
                & ((st_tx & shift_ff[7]) | (st_sack & ack_ff));
  wire dif_clr = sw_clr | cmd_comp | (wr_stat & wdat[`I2CSS_SB_DIF]);
  wire address_or_stop_flag_clr = sw_clr | cmd_comp | (wr_stat & wdat[`I2CSS_SB_ADDRESS_OR_STOP_FLAG]);
  wire transmit_clash_flag_clr = start_det | (wr_stat & wdat[`I2CSS_SB_TRANSMIT_CLASH_FLAG]);
  wire berr_clr = wr_stat & wdat[`I2CSS_SB_BERR];
  // ----------------------------------------
  // pins and bus outputs
  // ----------------------------------------
  assign scl_o = 1'h0;
  assign sda_o = 1'h0;
  // hold scl low while a flag is pending, except in idle
  assign scl_oe_o = stretch_ff;
  assign sda_oe_o = sda_drv_ff & ~transmit_clash_flag_ff;
  assign hreadyout_o = 1'h1;
  assign hresp_o = 1'h0;
  assign hrdata_o = hrdata_ff;
  // ----------------------------------------
  // synchronisers
  // ----------------------------------------
  // two stages, then edge history
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s1_ff <= 2'h3;
      s2_ff <= 2'h3;
      d_ff <= 2'h3;
    end else if (clk_en_i) begin
      s1_ff <= '{scl_i, sda_i};
      s2_ff <= s1_ff;
      d_ff <= s2_ff;
    end
  end
  // ----------------------------------------
  // bus slave
  // ----------------------------------------
  // capture address phase, answer reads at once
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      wr_pend_ff <= 1'h0;
      widx_ff <= `I2CSS_REG_RST;
      hrdata_ff <= 32'h0;
    end else if (clk_en_i) begin
      wr_pend_ff <= wr_a;
      widx_ff <= a_idx;
      if (rd_a) begin
        hrdata_ff <= {24'h0, rd_val};
      end
    end
  end
  // plain control registers
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ctrla_ff <= `I2CSS_REG_RST;
      ack_ff <= 1'h0;
      comp_ff <= 1'h0;
      own_ff <= `I2CSS_REG_RST;
      mask_ff <= `I2CSS_REG_RST;
    end else if (clk_en_i) begin
      if (wr_ctrla) ctrla_ff <= wdat;
      ack_ff <= ack_now;
      comp_ff <= comp_ack | (comp_ff & st_sack);
      if (wr_own) own_ff <= wdat;
      if (wr_mask) mask_ff <= wdat;
    end
  end
  // ----------------------------------------
  // status flags
  // ----------------------------------------
  // set wins over clear for every flag
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dif_ff <= 1'h0;
      address_or_stop_flag_ff <= 1'h0;
      transmit_clash_flag_ff <= 1'h0;
      berr_ff <= 1'h0;
    end else if (clk_en_i) begin
      dif_ff <= dif_set | (dif_ff & ~dif_clr);
      address_or_stop_flag_ff <= address_or_stop_flag_set | (address_or_stop_flag_ff & ~address_or_stop_flag_clr);
      transmit_clash_flag_ff <= transmit_clash_flag_set | (transmit_clash_flag_ff & ~transmit_clash_flag_clr);
      berr_ff <= berr_set | (berr_ff & ~berr_clr);
    end
  end
  // read-only bits follow the engine only
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      dir_ff <= 1'h0;
      ap_ff <= 1'h0;
      master_ack_seen_ff <= 1'h0;
      stretch_ff <= 1'h0;
    end else if (clk_en_i) begin
      if (ap_match) dir_ff <= shift_ff[0];
      if (address_or_stop_flag_set) ap_ff <= ap_match;
      if (st_mack & scl_rise) master_ack_seen_ff <= s2_ff.sda;
      stretch_ff <= (dif_ff | address_or_stop_flag_ff) & ~st_idle;
    end
  end
  // ----------------------------------------
  // byte engine
  // ----------------------------------------
  // state, counter and shift register
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      state_ff <= i2css_pkg::ST_IDLE;
      bit_ff <= 4'h0;
      shift_ff <= `I2CSS_REG_RST;
    end else if (clk_en_i) begin
      if (start_det & en) begin
        // a start while enabled opens an address byte
        state_ff <= i2css_pkg::ST_ADDR;
        bit_ff <= 4'h0;
      end else if (stop_det | (cmd_comp & ~comp_ack)) begin
        // stop or complete: wait for a start
        state_ff <= i2css_pkg::ST_IDLE;
        bit_ff <= 4'h0;
      end else if (wr_data & stretch_ff) begin
        // software loads only while held
        shift_ff <= wdat;
      end else begin
        unique case (state_ff)
          i2css_pkg::ST_IDLE: begin
            bit_ff <= 4'h0;
          end
          i2css_pkg::ST_ADDR, i2css_pkg::ST_RX: begin
            // sample on rise, decide after eighth fall
            if (scl_rise) begin
              shift_ff <= {shift_ff[6:0], s2_ff.sda};
              bit_ff <= bit_ff + 4'h1;
            end else if (scl_fall & byte_end) begin
              bit_ff <= 4'h0;
              if (st_rx | match) begin
                state_ff <= i2css_pkg::ST_SACK;
              end else begin
                state_ff <= i2css_pkg::ST_IDLE;
              end
            end
          end
          i2css_pkg::ST_SACK: begin
            // ack bit sent by us
            if (scl_fall) begin
              if (ack_ff | comp_ff) begin
                state_ff <= i2css_pkg::ST_IDLE;
              end else if (dir_ff) begin
                state_ff <= i2css_pkg::ST_TX;
              end else begin
                state_ff <= i2css_pkg::ST_RX;
              end
            end
          end
          i2css_pkg::ST_TX: begin
            // shift out on fall
            if (scl_rise) begin
              bit_ff <= bit_ff + 4'h1;
            end else if (scl_fall) begin
              shift_ff <= {shift_ff[6:0], 1'h1};
              if (byte_end) begin
                bit_ff <= 4'h0;
                state_ff <= i2css_pkg::ST_MACK;
              end
            end
          end
          i2css_pkg::ST_MACK: begin
            // master ack decides next byte
            if (scl_fall) begin
              if (master_ack_seen_ff) begin
                state_ff <= i2css_pkg::ST_IDLE;
              end else begin
                state_ff <= i2css_pkg::ST_TX;
              end
            end
          end
          default: begin
            state_ff <= i2css_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end
  // sda drive: low for ack or zero data bit
  always_ff @(posedge core_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      sda_drv_ff <= 1'h0;
    end else if (clk_en_i) begin
      sda_drv_ff <= ~stop_det & ~start_det
                  & ((st_sack & ~ack_ff) | (st_tx & ~shift_ff[7]));
    end
  end
  // ----------------------------------------
  // checks
  // ----------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_b_i);
  chk_dif_w1c: assert property (
    clk_en_i & wr_stat & wdat[`I2CSS_SB_DIF] & ~dif_set |=> ~dif_ff)
    else $error("data flag not cleared by write one");
  chk_dif_auto: assert property (
    clk_en_i & sw_clr & ~dif_set |=> ~dif_ff) else $error("data flag not cleared by access");
  chk_stop_cause: assert property (
    clk_en_i & stop_det & ctrla_ff[`I2CSS_CA_STOPEN]
    |=> address_or_stop_flag_ff & ~ap_ff)
    else $error("stop did not set flag with stop cause");
  chk_hold_scl: assert property (
    clk_en_i & (dif_ff | address_or_stop_flag_ff) & ~st_idle |=> scl_oe_o)
    else $error("scl not held while flag pending");
  chk_hold_free: assert property (
    clk_en_i & ~dif_ff & ~address_or_stop_flag_ff |=> ~scl_oe_o)
    else $error("scl held with no flag");
  chk_transmit_clash_flag_start: assert property (
    clk_en_i & start_det & ~transmit_clash_flag_set |=> ~transmit_clash_flag_ff)
    else $error("collision flag survived start");
  chk_transmit_clash_flag_quiet: assert property (
    transmit_clash_flag_ff |-> ~sda_oe_o)
    else $error("sda driven after collision");
  chk_addr_hit: assert property (
    clk_en_i & a_done & match
    |=> address_or_stop_flag_ff & ap_ff & (dir_ff == $past(shift_ff[0])))
    else $error("address match not flagged");
  chk_berr_ss: assert property (
    clk_en_i & master_enable_i & stop_det & st_addr |=> berr_ff)
    else $error("start then stop not flagged");
  chk_master_ack_seen_cap: assert property (
    clk_en_i & st_mack & scl_rise |=> master_ack_seen_ff == $past(s2_ff.sda))
    else $error("master ack not captured");
  cov_addressed: cover property (clk_en_i & ap_match);
  cov_rx_byte: cover property (clk_en_i & r_done);
  cov_collide: cover property (clk_en_i & transmit_clash_flag_set);
endmodule : i2css_top

// ---- include/i2css_defines.svh ----
`ifndef I2CSS_DEFINES_SVH
`define I2CSS_DEFINES_SVH
// ----------------------------------------
// register indices (byte address = 4 * index)
// ----------------------------------------
`define I2CSS_IDX_CTRLA  8'h09
`define I2CSS_IDX_CTRLB  8'h0A
`define I2CSS_IDX_STATUS 8'h0B
`define I2CSS_IDX_OWN    8'h0C
`define I2CSS_IDX_DATA   8'h0D
`define I2CSS_IDX_MASK   8'h0E
// ----------------------------------------
// field positions and codes
// ----------------------------------------
`define I2CSS_CA_EN      0
`define I2CSS_CA_ANY     2
`define I2CSS_CA_STOPEN  5
`define I2CSS_CA_RMASK   8'h25
`define I2CSS_CB_ACK     2
`define I2CSS_CMD_COMP   2'h2
`define I2CSS_CMD_RESP   2'h3
`define I2CSS_SB_DIF     7
`define I2CSS_SB_ADDRESS_OR_STOP_FLAG    6
`define I2CSS_SB_TRANSMIT_CLASH_FLAG    3
`define I2CSS_SB_BERR    2
`define I2CSS_REG_RST    8'h00
`define I2CSS_BITS       4'h8
`define I2CSS_GC_ADDR    7'h00
`define I2CSS_HT_ACT     1
`endif

// ---- include/i2css_pkg.sv ----
package i2css_pkg;
  // status register layout, msb first
  typedef struct packed {
    logic data_done_flag;
    logic address_or_stop_flag;
    logic stretch;
    logic master_ack_seen;
    logic transmit_clash_flag;
    logic berr;
    logic dir;
    logic ap;
  } i2css_status_t;
  // synchronised line pair
  typedef struct packed {
    logic scl;
    logic sda;
  } i2css_line_t;
  // byte engine states
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_ADDR = 6'h02,
    ST_SACK = 6'h04,
    ST_RX   = 6'h08,
    ST_TX   = 6'h10,
    ST_MACK = 6'h20
  } i2css_state_t;
endpackage : i2css_pkg

// ---- tb/i2css_bus_master.sv ----
`timescale 1ns/1ps
// ----------------------------------------
// two-wire bus master model
// ----------------------------------------
module i2css_bus_master (
  // bus levels seen on the wires
  input  wire logic scl_i,
  input  wire logic sda_i,
  // open-drain pulls, high = line pulled low
  output logic      scl_pull_o,
  output logic      sda_pull_o
);
  localparam int HALF = 32; // 64 ns link period, many core clocks per half
  // released lines float high through the pull-ups
  initial begin
    scl_pull_o = 1'h0;
    sda_pull_o = 1'h0;
  end
  // one bit: data while low, clock high, sample, pull clock low again
  task automatic bit_io(input logic b, output logic r);
    #8 sda_pull_o <= ~b;
    #24 scl_pull_o <= 1'h0;
    wait (scl_i === 1'h1); // slave may stretch the low phase
    #HALF r = sda_i;
    scl_pull_o <= 1'h1;
  endtask : bit_io
  // start or repeated start: data falls while clock high
  task automatic send_start();
    sda_pull_o <= 1'h0;
    #HALF scl_pull_o <= 1'h0;
    wait (scl_i === 1'h1);
    #HALF sda_pull_o <= 1'h1;
    #HALF scl_pull_o <= 1'h1;
    #HALF;
  endtask : send_start
  // stop: data rises while clock high
  task automatic send_stop();
    #8 sda_pull_o <= 1'h1;
    #24 scl_pull_o <= 1'h0;
    wait (scl_i === 1'h1);
    #HALF sda_pull_o <= 1'h0;
    #HALF;
  endtask : send_stop
  // byte out msb first, then a pause so the slave flags land
  task automatic send_byte(input logic [7:0] b);
    logic r;
    for (int i = 7; i >= 0; i--) bit_io(b[i], r);
    #40;
  endtask : send_byte
  // byte in; a set pull bit drives low against the slave
  task automatic read_byte(input logic [7:0] pull, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) bit_io(~pull[i], d[i]);
    #40;
  endtask : read_byte
  // ninth bit: master level in, wire level out
  task automatic ack_bit(input logic b, output logic r);
    bit_io(b, r);
    #40;
  endtask : ack_bit
endmodule : i2css_bus_master

// ---- tb/i2css_top_tb.sv ----
`timescale 1ns/1ps
`include "i2css_defines.svh"
module i2css_top_tb;
  // ----------------------------------------
  // signals
  // ----------------------------------------
  logic        core_clk, rst_b, hsel, hwrite, hreadyout, hresp, mst_en;
  logic        scl_o, sda_o, scl_oe, sda_oe, m_scl, m_sda, scl_bus, sda_bus;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata;
  logic [7:0]  st, d;
  logic        r;
  int          bad_count, checks_done;
  // wired-and of both parties, pull-up when released
  assign scl_bus = ~(m_scl | scl_oe);
  assign sda_bus = ~(m_sda | sda_oe);
  // address table: ctrl a, own, mask, ctrl b, address byte, match
  localparam logic [7:0] TBL [8][6] = '{
    '{8'h21, 8'h54, 8'h00, 8'h03, 8'h54, 8'h01}, '{8'h21, 8'h54, 8'h00, 8'h03, 8'h56, 8'h00},
    '{8'h21, 8'h55, 8'h00, 8'h02, 8'h00, 8'h01}, '{8'h21, 8'h54, 8'h00, 8'h02, 8'h00, 8'h00},
    '{8'h21, 8'hF2, 8'h00, 8'h02, 8'hF2, 8'h01}, '{8'h21, 8'h54, 8'h02, 8'h06, 8'h56, 8'h01},
    '{8'h21, 8'h54, 8'h61, 8'h02, 8'h60, 8'h01}, '{8'h25, 8'h00, 8'h00, 8'h02, 8'h3A, 8'h01}};
  // ----------------------------------------
  // design and far-side master
  // ----------------------------------------
  i2css_top DUT (.core_clk_i(core_clk), .clk_en_i(1'h1), .rst_b_i(rst_b), .hsel_i(hsel),
    .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
    .hready_i(hreadyout), .hreadyout_o(hreadyout), .hresp_o(hresp), .hrdata_o(hrdata),
    .scl_i(scl_bus), .scl_o(scl_o), .scl_oe_o(scl_oe), .sda_i(sda_bus), .sda_o(sda_o),
    .sda_oe_o(sda_oe), .master_enable_i(mst_en));
  i2css_bus_master mst (.scl_i(scl_bus), .sda_i(sda_bus), .scl_pull_o(m_scl),
    .sda_pull_o(m_sda));
  // free-running core clock, 4 ns period
  initial begin
    core_clk = 1'h0;
    forever #2 core_clk = ~core_clk;
  end
  // ----------------------------------------
  // checking and closing
  // ----------------------------------------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : check
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop
  // ----------------------------------------
  // ahb-lite master: hold each phase until hready
  // ----------------------------------------
  task automatic addr_phase(input logic [7:0] idx, input logic wr);
    @(posedge core_clk);
    hsel   <= 1'h1;
    haddr  <= {22'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    @(posedge core_clk);
    while (hreadyout !== 1'h1) @(posedge core_clk);
    hsel   <= 1'h0;
    htrans <= 2'h0;
  endtask : addr_phase
  task automatic bus_wr(input logic [7:0] idx, input logic [7:0] val);
    addr_phase(idx, 1'h1);
    hwdata <= {24'h0, val};
    @(posedge core_clk);
    while (hreadyout !== 1'h1) @(posedge core_clk);
  endtask : bus_wr
  task automatic bus_rd(input logic [7:0] idx, output logic [7:0] val);
    addr_phase(idx, 1'h0);
    @(posedge core_clk);
    while (hreadyout !== 1'h1) @(posedge core_clk);
    val = hrdata[7:0];
  endtask : bus_rd
  // status read and compare in one call
  task automatic st_is(input logic [7:0] exp, input string msg);
    logic [7:0] v;
    bus_rd(`I2CSS_IDX_STATUS, v);
    check(v, exp, msg);
  endtask : st_is
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reset values, read-only bits, unmapped place
  task automatic t_regs();
    st_is(8'h00, "status reset");
    bus_rd(`I2CSS_IDX_OWN, st);
    check(st, 8'h00, "own reset");
    bus_wr(`I2CSS_IDX_STATUS, 8'hFF);
    st_is(8'h00, "status write");
    bus_wr(`I2CSS_IDX_OWN, 8'hA5);
    bus_rd(`I2CSS_IDX_OWN, st);
    check(st, 8'hA5, "own rw");
    bus_rd(8'h30, st);
    check(st, 8'h00, "unmapped");
    $display("test regs done");
  endtask : t_regs
  // every match mode, with command, acknowledge level and stop
  task automatic t_match();
    for (int i = 0; i < 8; i++) begin
      bus_wr(`I2CSS_IDX_CTRLA, TBL[i][0]);
      bus_wr(`I2CSS_IDX_OWN, TBL[i][1]);
      bus_wr(`I2CSS_IDX_MASK, TBL[i][2]);
      mst.send_start();
      mst.send_byte(TBL[i][4]);
      st_is(TBL[i][5][0] ? 8'h61 : 8'h00, "match");
      check({7'h0, scl_oe}, TBL[i][5], "stretch");
      // clear through the command, not the status
      if (TBL[i][5][0]) bus_wr(`I2CSS_IDX_CTRLB, TBL[i][3]);
      st_is({7'h0, TBL[i][5][0]}, "command clear");
      mst.ack_bit(1'h1, r);
      check({7'h0, r}, {7'h0, ~TBL[i][5][0] | TBL[i][3][2]}, "ack level");
      mst.send_stop();
      st_is(8'h40, "stop flag");
      bus_wr(`I2CSS_IDX_STATUS, 8'h40);
      st_is(8'h00, "stop clear");
    end
    $display("test match done");
  endtask : t_match
  // master write: data flag, data read clears, data reaches register
  task automatic t_write();
    bus_wr(`I2CSS_IDX_CTRLA, 8'h21);
    bus_wr(`I2CSS_IDX_OWN, 8'h54);
    bus_wr(`I2CSS_IDX_MASK, 8'h00);
    mst.send_start();
    mst.send_byte(8'h54);
    bus_wr(`I2CSS_IDX_CTRLB, 8'h03);
    mst.ack_bit(1'h1, r);
    check({7'h0, r}, 8'h00, "address ack");
    mst.send_byte(8'hA5);
    st_is(8'hA1, "byte in");
    bus_rd(`I2CSS_IDX_DATA, st);
    check(st, 8'hA5, "data");
    st_is(8'h01, "data read clear");
    mst.ack_bit(1'h1, r);
    check({7'h0, r}, 8'h00, "data ack");
    mst.send_stop();
    bus_wr(`I2CSS_IDX_STATUS, 8'h40);
    $display("test write done");
  endtask : t_write
  // master read with a clash on the first bit, then nack
  task automatic t_read();
    mst.send_start();
    mst.send_byte(8'h55);
    st_is(8'h63, "read address");
    bus_wr(`I2CSS_IDX_CTRLB, 8'h03);
    mst.ack_bit(1'h1, r);
    st_is(8'hA3, "ready to send");
    bus_wr(`I2CSS_IDX_DATA, 8'hBC);
    st_is(8'h03, "data write clear");
    mst.read_byte(8'h80, d);
    check(d, 8'h7F, "no low after clash");
    mst.ack_bit(1'h1, r);
    st_is(8'h9B, "clash done nack");
    bus_wr(`I2CSS_IDX_STATUS, 8'h80);
    st_is(8'h1B, "data w1c");
    mst.send_start();
    st_is(8'h13, "start clears clash");
    mst.send_stop();
    st_is(8'h52, "stop cause");
    bus_wr(`I2CSS_IDX_STATUS, 8'h40);
    $display("test read done");
  endtask : t_read
  // start directly followed by stop, detector on and off
  task automatic t_illegal_bus_condition_flag();
    bus_wr(`I2CSS_IDX_CTRLA, 8'h01);
    // bus error detection needs the master side on
    mst_en <= 1'h1;
    mst.send_start();
    mst.send_stop();
    st_is(8'h16, "bus error");
    // software drops the packet and waits for a new start
    bus_wr(`I2CSS_IDX_STATUS, 8'h04);
    st_is(8'h12, "bus error w1c");
    mst_en <= 1'h0;
    mst.send_start();
    mst.send_stop();
    st_is(8'h12, "detector off");
    $display("test bus error done");
  endtask : t_illegal_bus_condition_flag
  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial begin
    rst_b = 1'h0;
    hsel = 1'h0;
    hwrite = 1'h0;
    htrans = 2'h0;
    haddr = 32'h0;
    hwdata = 32'h0;
    mst_en = 1'h0;
    bad_count = 0;
    checks_done = 0;
    repeat (5) @(posedge core_clk);
    rst_b <= 1'h1;
    t_regs();
    t_match();
    t_write();
    t_read();
    t_illegal_bus_condition_flag();
    report_and_stop();
  end
  // whole run is some 12 us of link traffic
  initial begin
    #200000;
    bad_count++;
    report_and_stop();
  end
endmodule : i2css_top_tb
